// file: shared/fsb_data_pkg.sv
package fsb_data_pkg;
   localparam int DATA_W      = 64;
   localparam int LANES       = 4;
   localparam int LANE_W      = 16;
   localparam int HALF_LANE   = 8;
   localparam int BURST_WORDS = 4;
   localparam int FIFO_DEPTH  = 32;
   localparam int LEVEL_W     = 6;
   localparam int SYS_CLK_HZ  = 20_000_000;

   // Bus clock is the host system clock divided by eight
   localparam logic [2:0] BUS_RISE_CNT = 3'h3;
   localparam logic [2:0] BUS_FALL_CNT = 3'h7;

   // Burst step counter: positive strobes fall after steps 0 and 4,
   // negative strobes after steps 2 and 6
   localparam logic [2:0] BURST_LAST = 3'h7;
   localparam logic [2:0] P_FALL_A   = 3'h0;
   localparam logic [2:0] P_FALL_B   = 3'h4;
   localparam logic [2:0] N_FALL_A   = 3'h2;
   localparam logic [2:0] N_FALL_B   = 3'h6;

   localparam logic [LEVEL_W-1:0] BURST_LEVEL    = 6'h04;
   localparam logic [LEVEL_W-1:0] ROOM_LEVEL_MAX = 6'h18;
   localparam logic [1:0]         GRANT_GAP      = 2'h2;

   typedef struct packed {
      logic [DATA_W-1:0] d;
      logic [LANES-1:0]  inv_n;
      logic [LANES-1:0]  sp_n;
      logic [LANES-1:0]  sn_n;
      logic              q_n;
   } pins_t;

   localparam pins_t PINS_IDLE = '1;
endpackage

// file: shared/fsb_data_if.sv
interface fsb_data_if;
   import fsb_data_pkg::*;
   logic  bus_clk;
   logic  grant;
   logic  room;
   pins_t dev_o;
   logic  dev_oe;
   pins_t host_o;
   logic  host_oe;
   pins_t line;

   // Pull-ups hold every idle line high
   assign line = dev_oe ? dev_o : (host_oe ? host_o : PINS_IDLE);

   modport device (input bus_clk, input grant, input line,
                   output dev_o, output dev_oe, output room);
   modport host (output bus_clk, output grant, output host_o, output host_oe,
                 input line, input room);
endinterface

// file: src/fsb_device_end.sv
module quad_pump
   import fsb_data_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   input  wire logic              start_i,
   input  wire logic [DATA_W-1:0] tx_data_i,
   output logic                   tx_take_o,
   output logic                   busy_o,
   output logic                   q_seen_o,
   input  wire pins_t             line_i,
   output pins_t                  pins_o,
   output logic                   oe_o,
   output logic                   rx_valid_o,
   output logic [DATA_W-1:0]      rx_data_o,
   input  wire logic              rx_ready_i
);
   logic       active_reg;
   logic [2:0] cnt_reg;
   pins_t      pins_reg;
   logic       oe_reg;
   logic       q_s1_reg;
   logic       q_s2_reg;
   logic       q_act_reg;
   logic       own_reg;
   logic [2:0] left_reg;
   logic       burst_end;
   logic       load;
   logic       shift;
   // Pins are active low; a lane goes out true-polarity when that saves toggles
   function automatic logic [DATA_W+LANES-1:0] encode(input logic [DATA_W-1:0] w,
                                                      input logic [DATA_W-1:0] prev);
      logic [LANE_W-1:0]        lane;
      logic [4:0]               flips;
      logic [DATA_W+LANES-1:0]  r;
      r = '0;
      for (int n = 0; n < LANES; n++) begin
         lane  = ~w[n*LANE_W +: LANE_W];
         flips = '0;
         for (int b = 0; b < LANE_W; b++) begin
            flips = flips + 5'(lane[b] ^ prev[n*LANE_W+b]);
         end
         if (flips > 5'(HALF_LANE)) begin
            r[n*LANE_W +: LANE_W] = ~lane;
            r[DATA_W+n]           = 1'b0;
         end else begin
            r[n*LANE_W +: LANE_W] = lane;
            r[DATA_W+n]           = 1'b1;
         end
      end
      return r;
   endfunction
   function automatic logic [LANE_W-1:0] decode(input logic [LANE_W:0] raw);
      return raw[LANE_W] ? ~raw[LANE_W-1:0] : raw[LANE_W-1:0];
   endfunction
   // Words are fetched at steps start, 1, 3 and 5 of the burst
   assign tx_take_o = start_i || (active_reg && cnt_reg[0] && cnt_reg != BURST_LAST);
   assign busy_o    = active_reg;
   assign pins_o    = pins_reg;
   assign oe_o      = oe_reg;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         active_reg <= 1'b0;
         cnt_reg    <= '0;
      end else if (start_i) begin
         active_reg <= 1'b1;
         cnt_reg    <= '0;
      end else if (active_reg) begin
         cnt_reg <= cnt_reg + 3'h1;
         if (cnt_reg == BURST_LAST) begin
            active_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pins_reg <= PINS_IDLE;
         oe_reg   <= 1'b0;
      end else begin
         if (tx_take_o) begin
            {pins_reg.inv_n, pins_reg.d} <= encode(tx_data_i, pins_reg.d);
         end
         pins_reg.sp_n <= {LANES{!(active_reg && (cnt_reg == P_FALL_A ||
                                                  cnt_reg == P_FALL_B))}};
         pins_reg.sn_n <= {LANES{!(active_reg && (cnt_reg == N_FALL_A ||
                                                  cnt_reg == N_FALL_B))}};
         pins_reg.q_n  <= !(start_i || (active_reg && cnt_reg != BURST_LAST));
         oe_reg        <= start_i || (active_reg && cnt_reg != BURST_LAST);
      end
   end
   // Qualifier is an asynchronous level, synchronized through two flops; it gates when captured words are taken
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q_s1_reg  <= 1'b1;
         q_s2_reg  <= 1'b1;
         q_act_reg <= 1'b0;
      end else begin
         q_s1_reg  <= line_i.q_n;
         q_s2_reg  <= q_s1_reg;
         q_act_reg <= !q_s2_reg;
      end
   end
   assign q_seen_o  = !q_s2_reg;
   assign burst_end = q_act_reg && q_s2_reg;
   assign load      = burst_end && !own_reg;
   assign shift     = rx_valid_o && rx_ready_i;
   assign rx_valid_o = left_reg != '0;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         own_reg <= 1'b0;
      end else if (start_i) begin
         own_reg <= 1'b1;
      end else if (burst_end) begin
         own_reg <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         left_reg <= '0;
      end else if (load) begin
         left_reg <= 3'(BURST_WORDS);
      end else if (shift) begin
         left_reg <= left_reg - 3'h1;
      end
   end
   // Strobe-clocked capture; the strobes are idle once the qualifier has
   // dropped, so the system domain reads stable words after the sync delay
   for (genvar n = 0; n < LANES; n++) begin : g_lane
      logic              slot_p;
      logic              slot_n;
      logic [LANE_W:0]   cap_p [2];
      logic [LANE_W:0]   cap_n [2];
      logic [LANE_W-1:0] word_reg [BURST_WORDS];
      always_ff @(negedge line_i.sp_n[n] or negedge reset_n_i) begin
         if (!reset_n_i) begin
            slot_p   <= 1'b0;
            cap_p    <= '{default: '1};
         end else begin
            slot_p         <= !slot_p;
            cap_p[slot_p]  <= {line_i.inv_n[n], line_i.d[n*LANE_W +: LANE_W]};
         end
      end
      always_ff @(negedge line_i.sn_n[n] or negedge reset_n_i) begin
         if (!reset_n_i) begin
            slot_n   <= 1'b0;
            cap_n    <= '{default: '1};
         end else begin
            slot_n         <= !slot_n;
            cap_n[slot_n]  <= {line_i.inv_n[n], line_i.d[n*LANE_W +: LANE_W]};
         end
      end
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            word_reg <= '{default: '0};
         end else if (load) begin
            word_reg[0] <= decode(cap_p[0]);
            word_reg[1] <= decode(cap_n[0]);
            word_reg[2] <= decode(cap_p[1]);
            word_reg[3] <= decode(cap_n[1]);
         end else if (shift) begin
            for (int k = 0; k < BURST_WORDS - 1; k++) begin
               word_reg[k] <= word_reg[k+1];
            end
         end
      end
      assign rx_data_o[n*LANE_W +: LANE_W] = word_reg[0];
   end
endmodule
module fsb_device_end
   import fsb_data_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   fsb_data_if.device             bus,
   input  wire logic              tx_valid_i,
   input  wire logic [DATA_W-1:0] tx_data_i,
   output logic                   tx_ready_o,
   output logic                   rx_valid_o,
   output logic [DATA_W-1:0]      rx_data_o,
   input  wire logic              rx_ready_i
);
   logic               bclk_s1_reg;
   logic               bclk_s2_reg;
   logic               bclk_prev_reg;
   logic               gr_s1_reg;
   logic               gr_s2_reg;
   logic               room_reg;
   logic               bus_edge;
   logic               start;
   logic               take;
   logic               busy;
   logic               q_seen;
   logic [DATA_W-1:0]  tx_word;
   logic [LEVEL_W-1:0] tx_level;
   logic [LEVEL_W-1:0] rx_level;
   logic               prx_valid;
   logic               prx_ready;
   logic [DATA_W-1:0]  prx_data;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bclk_s1_reg   <= 1'b0;
         bclk_s2_reg   <= 1'b0;
         bclk_prev_reg <= 1'b0;
         gr_s1_reg     <= 1'b0;
         gr_s2_reg     <= 1'b0;
      end else begin
         bclk_s1_reg   <= bus.bus_clk;
         bclk_s2_reg   <= bclk_s1_reg;
         bclk_prev_reg <= bclk_s2_reg;
         gr_s1_reg     <= bus.grant;
         gr_s2_reg     <= gr_s1_reg;
      end
   end
   // Grant and room are sampled at the bus clock rise so they stay coherent
   assign bus_edge = bclk_s2_reg && !bclk_prev_reg;
   assign start    = bus_edge && gr_s2_reg && !q_seen && !busy && tx_level >= BURST_LEVEL;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         room_reg <= 1'b0;
      end else if (bus_edge) begin
         room_reg <= rx_level <= ROOM_LEVEL_MAX;
      end
   end
   assign bus.room = room_reg;
   stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (),
      .out_ready_i (take),
      .out_data_o  (tx_word),
      .level_o     (tx_level)
   );
   quad_pump u_pump (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .start_i    (start),
      .tx_data_i  (tx_word),
      .tx_take_o  (take),
      .busy_o     (busy),
      .q_seen_o   (q_seen),
      .line_i     (bus.line),
      .pins_o     (bus.dev_o),
      .oe_o       (bus.dev_oe),
      .rx_valid_o (prx_valid),
      .rx_data_o  (prx_data),
      .rx_ready_i (prx_ready)
   );
   stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (prx_valid),
      .in_ready_o  (prx_ready),
      .in_data_i   (prx_data),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (rx_data_o),
      .level_o     (rx_level)
   );
endmodule

// file: src/fsb_host_end.sv
module stream_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32,
   parameter int PTR_W = $clog2(DEPTH)
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o,
   output logic [PTR_W:0]        level_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_reg;
   logic [PTR_W-1:0] rd_reg;
   logic [PTR_W:0]   cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_o  = cnt_reg != (PTR_W+1)'(DEPTH);
   assign out_valid_o = cnt_reg != '0;
   assign out_data_o  = mem_reg[rd_reg];
   assign level_o     = cnt_reg;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_reg + PTR_W'(push);
         rd_reg  <= rd_reg + PTR_W'(pop);
         cnt_reg <= cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end
endmodule

module fsb_host_end
   import fsb_data_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   fsb_data_if.host               bus,
   input  wire logic              tx_valid_i,
   input  wire logic [DATA_W-1:0] tx_data_i,
   output logic                   tx_ready_o,
   output logic                   rx_valid_o,
   output logic [DATA_W-1:0]      rx_data_o,
   input  wire logic              rx_ready_i
);
   logic [2:0]         div_reg;
   logic               bclk_reg;
   logic               grant_reg;
   logic [1:0]         gap_reg;
   logic               room_s1_reg;
   logic               room_s2_reg;
   logic               bus_edge;
   logic               want_grant;
   logic               start;
   logic               take;
   logic               busy;
   logic               q_seen;
   logic [DATA_W-1:0]  tx_word;
   logic [LEVEL_W-1:0] tx_level;
   logic [LEVEL_W-1:0] rx_level;
   logic               prx_valid;
   logic               prx_ready;
   logic [DATA_W-1:0]  prx_data;

   assign bus_edge   = div_reg == BUS_RISE_CNT;
   assign want_grant = tx_level < BURST_LEVEL && rx_level <= ROOM_LEVEL_MAX;
   // Own burst only after the grant has been low long enough to drain any
   // burst the far end began before it saw the grant fall
   assign start = bus_edge && !grant_reg && gap_reg == GRANT_GAP && room_s2_reg &&
                  !q_seen && !busy && tx_level >= BURST_LEVEL;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg  <= '0;
         bclk_reg <= 1'b0;
      end else begin
         div_reg <= div_reg + 3'h1;
         if (div_reg == BUS_RISE_CNT) begin
            bclk_reg <= 1'b1;
         end else if (div_reg == BUS_FALL_CNT) begin
            bclk_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         grant_reg <= 1'b0;
         gap_reg   <= '0;
      end else if (bus_edge) begin
         grant_reg <= want_grant;
         if (grant_reg) begin
            gap_reg <= '0;
         end else if (gap_reg != GRANT_GAP) begin
            gap_reg <= gap_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         room_s1_reg <= 1'b0;
         room_s2_reg <= 1'b0;
      end else begin
         room_s1_reg <= bus.room;
         room_s2_reg <= room_s1_reg;
      end
   end

   assign bus.bus_clk = bclk_reg;
   assign bus.grant   = grant_reg;

   stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (tx_valid_i),
      .in_ready_o  (tx_ready_o),
      .in_data_i   (tx_data_i),
      .out_valid_o (),
      .out_ready_i (take),
      .out_data_o  (tx_word),
      .level_o     (tx_level)
   );

   quad_pump u_pump (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .start_i    (start),
      .tx_data_i  (tx_word),
      .tx_take_o  (take),
      .busy_o     (busy),
      .q_seen_o   (q_seen),
      .line_i     (bus.line),
      .pins_o     (bus.host_o),
      .oe_o       (bus.host_oe),
      .rx_valid_o (prx_valid),
      .rx_data_o  (prx_data),
      .rx_ready_i (prx_ready)
   );

   stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_sys_i   (clk_sys_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (prx_valid),
      .in_ready_o  (prx_ready),
      .in_data_i   (prx_data),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (rx_data_o),
      .level_o     (rx_level)
   );
endmodule

// file: dv/fsb_data_monitor.sv
module fsb_data_monitor
   import fsb_data_pkg::*;
(
   input  wire logic  clk_sys_i,
   input  wire logic  reset_n_i,
   input  wire logic  bus_clk,
   input  wire logic  grant,
   input  wire logic  room,
   input  wire pins_t dev_o,
   input  wire logic  dev_oe,
   input  wire pins_t host_o,
   input  wire logic  host_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0]  strb;
   logic [67:0] word;

   assign strb = {host_o.sp_n, host_o.sn_n};
   assign word = {host_o.d, host_o.inv_n};

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   // Flags a lane that toggles too much, or an inversion that saved nothing
   function automatic logic dbi_bad(pins_t cur, pins_t prv);
      int c;
      dbi_bad = 1'b0;
      for (int n = 0; n < LANES; n++) begin
         c = $countones(cur.d[n*LANE_W +: LANE_W] ^ prv.d[n*LANE_W +: LANE_W]);
         if (c > HALF_LANE || (c == HALF_LANE && !cur.inv_n[n])) dbi_bad = 1'b1;
      end
   endfunction

   a_host_qual_tie: assert property (host_oe == !host_o.q_n)
      else $error("host qualifier and drive enable disagree");
   a_dev_qual_tie: assert property (dev_oe == !dev_o.q_n)
      else $error("device qualifier and drive enable disagree");
   a_single_driver: assert property (!(host_oe && dev_oe))
      else $error("both ends drive the data lines");
   a_burst_one_clock: assert property ($rose(host_oe) |-> host_oe [*8] ##1 !host_oe)
      else $error("host burst not one bus clock long");
   a_strobe_walk: assert property ($rose(host_oe) |-> strb == 8'hFF ##1 strb == 8'h0F
      ##1 strb == 8'hFF ##1 strb == 8'hF0 ##1 strb == 8'hFF ##1 strb == 8'h0F
      ##1 strb == 8'hFF ##1 strb == 8'hF0)
      else $error("strobe phases out of order");
   a_word_flag_pair: assert property ($rose(host_oe) |-> ##1 $stable(word)
      ##2 $stable(word) ##2 $stable(word) ##2 $stable(word))
      else $error("data or flag moved under a strobe");
   a_dbi_limit: assert property (!dbi_bad(host_o, $past(host_o)))
      else $error("lane inversion choice wrong");
   a_bus_clk_div: assert property ($rose(bus_clk) |->
      bus_clk [*4] ##1 !bus_clk [*4] ##1 bus_clk)
      else $error("bus clock period wrong");
   a_grant_quiet: assert property ($rose(host_oe) |->
      !grant && !$past(grant) && !$past(grant, 8) && !$past(grant, 16))
      else $error("host drove while device held the grant");

   c_host_burst: cover property ($rose(host_oe));
   c_dev_burst: cover property ($rose(dev_oe));
   c_lane_flip: cover property (host_oe && host_o.inv_n != 4'hF);
   c_room_low: cover property ($fell(room));
endmodule

// file: dv/tb.sv
module tb;
   import fsb_data_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [15:0] PAT [6] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'h01FF, 16'hAAAA, 16'h5555};

   logic              clk_h, clk_d, rst_n, stall;
   logic              h_tv, h_tr, h_rv, h_rr, d_tv, d_tr, d_rv, d_rr;
   logic [DATA_W-1:0] h_td, h_rd, d_td, d_rd;
   logic [DATA_W-1:0] q_h2d [$];
   logic [DATA_W-1:0] q_d2h [$];
   int                num_errors, n_checks, refused;

   fsb_data_if fb ();

   fsb_host_end i_fsb_host_end (.clk_sys_i(clk_h), .reset_n_i(rst_n), .bus(fb.host),
      .tx_valid_i(h_tv), .tx_data_i(h_td), .tx_ready_o(h_tr),
      .rx_valid_o(h_rv), .rx_data_o(h_rd), .rx_ready_i(h_rr));

   fsb_device_end i_fsb_device_end (.clk_sys_i(clk_d), .reset_n_i(rst_n), .bus(fb.device),
      .tx_valid_i(d_tv), .tx_data_i(d_td), .tx_ready_o(d_tr),
      .rx_valid_o(d_rv), .rx_data_o(d_rd), .rx_ready_i(d_rr));

   fsb_data_monitor i_fsb_data_monitor (.clk_sys_i(clk_h), .reset_n_i(rst_n),
      .bus_clk(fb.bus_clk), .grant(fb.grant), .room(fb.room), .dev_o(fb.dev_o),
      .dev_oe(fb.dev_oe), .host_o(fb.host_o), .host_oe(fb.host_oe));

   initial begin
      clk_h = 1'b0;
      forever #25 clk_h = ~clk_h;
   end

   // Both ends run at the system rate; the offset keeps their edges apart,
   // and a faster device clock would make its qualifier too short to sync
   initial begin
      clk_d = 1'b0;
      #17;
      forever #25 clk_d = ~clk_d;
   end

   task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Lane patterns walk through full, exact-half and single toggles
   function automatic logic [DATA_W-1:0] pat_word(int i, bit dbi);
      if (!dbi) return {$urandom, $urandom};
      return {PAT[(i + 3) % 6], PAT[(i + 2) % 6], PAT[(i + 1) % 6], PAT[i % 6]};
   endfunction

   task automatic run_h(int n, bit dbi);
      @(posedge clk_h);
      #1;
      for (int i = 0; i < n; i++) begin
         h_tv = 1'b1;
         h_td = pat_word(i, dbi);
         q_h2d.push_back(h_td);
         while (h_tr !== 1'b1) begin
            refused++;
            @(posedge clk_h);
            #1;
         end
         @(posedge clk_h);
         #1;
      end
      h_tv = 1'b0;
   endtask

   task automatic run_d(int n, bit dbi);
      @(posedge clk_d);
      #1;
      for (int i = 0; i < n; i++) begin
         d_tv = 1'b1;
         d_td = pat_word(i + 2, dbi);
         q_d2h.push_back(d_td);
         while (d_tr !== 1'b1) begin
            @(posedge clk_d);
            #1;
         end
         @(posedge clk_d);
         #1;
      end
      d_tv = 1'b0;
   endtask

   always @(posedge clk_d) begin
      if (d_rv === 1'b1 && d_rr === 1'b1) begin
         chk("word at device", q_h2d.size() > 0 ? q_h2d.pop_front() : 'x, d_rd);
      end
      #1;
      d_rr = !stall && ($urandom_range(3) != 0);
   end

   always @(posedge clk_h) begin
      if (h_rv === 1'b1 && h_rr === 1'b1) begin
         chk("word at host", q_d2h.size() > 0 ? q_d2h.pop_front() : 'x, h_rd);
      end
      #1;
      h_rr = ($urandom_range(3) != 0);
   end

   initial begin
      {h_tv, d_tv, stall} = 3'h0;
      {h_rr, d_rr} = 2'h3;
      h_td = '0;
      d_td = '0;
      num_errors = 0;
      n_checks = 0;
      refused = 0;
      rst_n = 1'b0;
      void'($urandom(32'h988B489B));
      repeat (6) @(posedge clk_h);
      #1;
      rst_n = 1'b1;
      fork
         run_h(32, 1'b0);
         run_d(32, 1'b0);
      join
      fork
         run_h(24, 1'b1);
         run_d(24, 1'b1);
      join
      // Stalled device reader drops room; 96 words exceed both buffers, so the
      // host buffer must fill and refuse
      refused = 0;
      stall = 1'b1;
      fork
         run_h(96, 1'b0);
         begin
            repeat (600) @(posedge clk_h);
            #1;
            stall = 1'b0;
         end
      join
      for (int i = 0; i < 20000 && q_h2d.size() + q_d2h.size() > 0; i++) @(posedge clk_h);
      repeat (20) @(posedge clk_h);
      chk("host buffer refused", 64'h1, 64'(refused > 0));
      chk("words outstanding", 64'h0, 64'(q_h2d.size() + q_d2h.size()));
      chk("receivers empty", 64'h0, 64'({h_rv, d_rv}));
      give_verdict();
   end

   initial begin
      repeat (40000) @(posedge clk_h);
      num_errors++;
      give_verdict();
   end
endmodule
